// File: src/udrct_params.svh
/*
 Named constants of the up/down reload/capture timer: register map,
 field masks, reset values and prescaler counts.
 Assumes inclusion by bare name from the package and the test files.
*/
`ifndef UDRCT_PARAMS_SVH
`define UDRCT_PARAMS_SVH

// Instances: index 0, 1 and 2 stand for timers 2, 3 and 4
`define UDRCT_INSTANCES      3
`define UDRCT_INST_TOGGLE_N  1
`define UDRCT_ADC_TRIGGERS   2

// Sampled pins: shared count, shared strobe, own count, own strobe, oscillator
`define UDRCT_PINS           5
`define UDRCT_P_SC           0
`define UDRCT_P_SS           1
`define UDRCT_P_OC           2
`define UDRCT_P_OS           3
`define UDRCT_P_OSC          4

// Byte address layout: bit 7 clear, bits 6:5 instance, bits 4:0 offset
`define UDRCT_ADDR_W         8
`define UDRCT_INST_MSB       6
`define UDRCT_INST_LSB       5
`define UDRCT_OFF_W          5
`define UDRCT_OFF_CONTROL    5'h00
`define UDRCT_OFF_CONFIG     5'h04
`define UDRCT_OFF_COUNT_LO   5'h08
`define UDRCT_OFF_COUNT_HI   5'h0c
`define UDRCT_OFF_RC_LO      5'h10
`define UDRCT_OFF_RC_HI      5'h14

// Field masks, reserved bits read zero
`define UDRCT_CTRL_MASK      8'hcf
`define UDRCT_CFG_MASK       8'h1f
`define UDRCT_CFG_MASK_NOTOG 8'h19

`define UDRCT_BYTE_W         8
`define UDRCT_COUNT_W        16
`define UDRCT_COUNT_MAX      16'hffff
`define UDRCT_COUNT_ZERO     16'h0000
`define UDRCT_COUNT_ONE      16'h0001
`define UDRCT_BYTE_ZERO      8'h00
`define UDRCT_WORD_ZERO      32'h00000000
`define UDRCT_PAD_W          24

// Prescalers
`define UDRCT_DIV12_LAST     4'hb
`define UDRCT_DIV12_ZERO     4'h0
`define UDRCT_DIV12_ONE      4'h1
`define UDRCT_EXT8_LAST      3'h7
`define UDRCT_EXT8_ZERO      3'h0
`define UDRCT_EXT8_ONE       3'h1

`endif

// File: src/udrct_pkg.sv
/*
 Types of the up/down reload/capture timer: clock-select encoding and the
 per-instance register state carried as packed structs.
 Assumes the constants header is on the include path.
*/
`include "udrct_params.svh"

package udrct_pkg;

	typedef enum logic [1:0]
	{
		UDRCT_CLK_DIV12 = 2'b00,
		UDRCT_CLK_FULL  = 2'b01,
		UDRCT_CLK_EXT8  = 2'b10,
		UDRCT_CLK_DIV2  = 2'b11
	} udrct_clk_sel_type;

	// Bit order matches the control byte
	typedef struct packed
	{
		logic       wrapFlag;
		logic       externalFlag;
		logic [1:0] reserved;
		logic       externalEnable;
		logic       runControl;
		logic       counterSelect;
		logic       captureReloadSelect;
	} udrct_ctrl_type;

	// Bit order matches the config byte
	typedef struct packed
	{
		logic [2:0]        reserved;
		udrct_clk_sel_type clockSelect;
		logic              toggleState;
		logic              toggleOutputEnable;
		logic              decrementEnable;
	} udrct_cfg_type;

	typedef struct packed
	{
		udrct_ctrl_type              ctrl;
		udrct_cfg_type               cfg;
		logic [`UDRCT_COUNT_W-1:0]   count;
		logic [`UDRCT_COUNT_W-1:0]   reloadCapture;
	} udrct_inst_type;

endpackage

// File: src/udrct_pin_sampler.sv
/*
 Samples one pin with the system clock and gives its level and its
 falling and rising edges as one-cycle pulses.
 Assumes the reset input is already synchronised to sys_clk.
*/
`timescale 1ns/10ps

module udrct_pin_sampler
	import udrct_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic resetN,
	input  wire logic pinIn,
	output logic      level,
	output logic      fall,
	output logic      rise
);

	logic stage1;
	logic stage2;
	logic stage3;
	logic next_stage1;
	logic next_stage2;
	logic next_stage3;

	always_comb
	begin
		next_stage1 = pinIn;
		next_stage2 = stage1;
		next_stage3 = stage2;
	end

	always_ff @(posedge sys_clk or negedge resetN)
	begin
		if (!resetN)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end
		else
		begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
			stage3 <= next_stage3;
		end
	end

	// Edges judged from stages two and three only
	assign level = stage2;
	assign fall  = stage3 & ~stage2;
	assign rise  = stage2 & ~stage3;

endmodule

// File: src/udrct_timer.sv
/*
 Three 16-bit up/down counter/timers with capture and auto-reload modes,
 toggle output on the first and third, behind an Avalon-MM slave.
 Assumes pins synchronous to sys_clk, an external oscillator clock slower
 than sys_clk, and a master that holds each request until waitrequest low.
*/
`timescale 1ns/10ps

module udrct_timer
	import udrct_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic [`UDRCT_ADDR_W-1:0]  avsAddress,
	input  wire logic                      avsRead,
	input  wire logic                      avsWrite,
	input  wire logic [31:0]               avsWriteData,
	input  wire logic [3:0]                avsByteEnable,
	output logic      [31:0]               avsReadData,
	output logic                           avsWaitRequest,
	input  wire logic                      sharedCountPin,
	input  wire logic                      sharedStrobePin,
	input  wire logic                      ownCountPin,
	input  wire logic                      ownStrobePin,
	input  wire logic                      oscillatorClock,
	output logic      [`UDRCT_INSTANCES-1:0] toggleOut,
	output logic      [`UDRCT_INSTANCES-1:0] toggleOutEnable,
	output logic      [`UDRCT_INSTANCES-1:0] wrapEvent,
	output logic      [`UDRCT_ADC_TRIGGERS-1:0] adcStart
);

	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rstMetaN;
	logic rstSyncN;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMetaN <= 1'b0;
			rstSyncN <= 1'b0;
		end
		else
		begin
			rstMetaN <= 1'b1;
			rstSyncN <= rstMetaN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sampling

	logic [`UDRCT_PINS-1:0] pinRaw;
	logic [`UDRCT_PINS-1:0] pinLevel;
	logic [`UDRCT_PINS-1:0] pinFall;
	logic [`UDRCT_PINS-1:0] pinRise;

	assign pinRaw = {oscillatorClock, ownStrobePin, ownCountPin, sharedStrobePin, sharedCountPin};

	for (genvar k = 0; k < `UDRCT_PINS; k++)
	begin : gSample
		udrct_pin_sampler sampler
		(
			.sys_clk (sys_clk),
			.resetN  (rstSyncN),
			.pinIn   (pinRaw[k]),
			.level   (pinLevel[k]),
			.fall    (pinFall[k]),
			.rise    (pinRise[k])
		);
	end

	// Instances 0 and 1 see the same pins
	logic [`UDRCT_INSTANCES-1:0] countFall;
	logic [`UDRCT_INSTANCES-1:0] strobeFall;
	logic [`UDRCT_INSTANCES-1:0] strobeLevel;
	logic                        oscRise;

	assign countFall   = {pinFall[`UDRCT_P_OC], pinFall[`UDRCT_P_SC], pinFall[`UDRCT_P_SC]};
	assign strobeFall  = {pinFall[`UDRCT_P_OS], pinFall[`UDRCT_P_SS], pinFall[`UDRCT_P_SS]};
	assign strobeLevel = {pinLevel[`UDRCT_P_OS],
		pinLevel[`UDRCT_P_SS], pinLevel[`UDRCT_P_SS]};
	assign oscRise     = pinRise[`UDRCT_P_OSC];

	////////////////////////////////////////////////////////////////////////
	// Shared prescalers

	logic       half;
	logic [3:0] div12Count;
	logic [2:0] ext8Count;
	logic       next_half;
	logic [3:0] next_div12Count;
	logic [2:0] next_ext8Count;
	logic       div12Tick;
	logic       ext8Tick;

	assign div12Tick = (div12Count == `UDRCT_DIV12_LAST);
	assign ext8Tick  = oscRise & (ext8Count == `UDRCT_EXT8_LAST);

	always_comb
	begin
		next_half       = ~half;
		next_div12Count = div12Tick ? `UDRCT_DIV12_ZERO : div12Count + `UDRCT_DIV12_ONE;
		next_ext8Count  = oscRise ? ext8Count + `UDRCT_EXT8_ONE : ext8Count;
	end

	always_ff @(posedge sys_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			half       <= 1'b0;
			div12Count <= `UDRCT_DIV12_ZERO;
			ext8Count  <= `UDRCT_EXT8_ZERO;
		end
		else
		begin
			half       <= next_half;
			div12Count <= next_div12Count;
			ext8Count  <= next_ext8Count;
		end
	end

	// Timer-function tick for a clock select code
	function automatic logic clockTick(udrct_clk_sel_type sel);
		logic tick;
		tick = 1'b0;
		unique case (sel)
			UDRCT_CLK_DIV12: tick = div12Tick;
			UDRCT_CLK_FULL:  tick = 1'b1;
			UDRCT_CLK_EXT8:  tick = ext8Tick;
			UDRCT_CLK_DIV2:  tick = half;
		endcase
		return tick;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register access helpers

	function automatic logic [`UDRCT_BYTE_W-1:0] readByte(udrct_inst_type s,
		logic [`UDRCT_OFF_W-1:0] off);
		logic [`UDRCT_BYTE_W-1:0] data;
		data = `UDRCT_BYTE_ZERO;
		case (off)
			`UDRCT_OFF_CONTROL:  data = s.ctrl & `UDRCT_CTRL_MASK;
			`UDRCT_OFF_CONFIG:   data = s.cfg & `UDRCT_CFG_MASK;
			`UDRCT_OFF_COUNT_LO: data = s.count[7:0];
			`UDRCT_OFF_COUNT_HI: data = s.count[15:8];
			`UDRCT_OFF_RC_LO:    data = s.reloadCapture[7:0];
			`UDRCT_OFF_RC_HI:    data = s.reloadCapture[15:8];
			default:             data = `UDRCT_BYTE_ZERO;
		endcase
		return data;
	endfunction

	function automatic logic [1:0] instOf(logic [`UDRCT_ADDR_W-1:0] addr);
		return addr[`UDRCT_INST_MSB:`UDRCT_INST_LSB];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave

	logic        requestSeen;
	logic        writeNow;
	logic        addrInRange;
	logic [1:0]  accessInst;
	logic [`UDRCT_OFF_W-1:0] accessOff;
	logic        next_avsWaitRequest;
	logic [31:0] next_avsReadData;

	udrct_inst_type state [`UDRCT_INSTANCES];
	udrct_inst_type next_state [`UDRCT_INSTANCES];

	assign accessInst  = instOf(avsAddress);
	assign accessOff   = avsAddress[`UDRCT_OFF_W-1:0];
	assign addrInRange = ~avsAddress[`UDRCT_ADDR_W-1] & (accessInst < 2'(`UDRCT_INSTANCES));
	assign requestSeen = (avsRead | avsWrite) & avsWaitRequest;
	// A write lands at the edge where waitrequest is seen low
	assign writeNow    = avsWrite & ~avsWaitRequest & avsByteEnable[0] & addrInRange;

	always_comb
	begin
		next_avsWaitRequest = ~requestSeen;
		next_avsReadData    = avsReadData;
		if (requestSeen && avsRead)
			next_avsReadData = addrInRange
				? {{`UDRCT_PAD_W{1'b0}}, readByte(state[accessInst], accessOff)}
				: `UDRCT_WORD_ZERO;
	end

	always_ff @(posedge sys_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			avsWaitRequest <= 1'b1;
			avsReadData    <= `UDRCT_WORD_ZERO;
		end
		else
		begin
			avsWaitRequest <= next_avsWaitRequest;
			avsReadData    <= next_avsReadData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter instances

	logic [`UDRCT_INSTANCES-1:0] next_wrapEvent;

	always_comb
	begin
		next_wrapEvent = '0;
		for (int i = 0; i < `UDRCT_INSTANCES; i++)
		begin
			udrct_inst_type cur;
			logic           hit;
			logic           strobeEdge;
			logic           countUp;
			logic           tick;
			logic           wrap;
			logic           extSet;
			logic [`UDRCT_COUNT_W-1:0] hwCount;
			logic [`UDRCT_COUNT_W-1:0] hwReload;
			logic [`UDRCT_BYTE_W-1:0]  cfgMask;
			cur        = state[i];
			hit        = writeNow & (accessInst == 2'(i));
			strobeEdge = strobeFall[i] & cur.ctrl.externalEnable
				& ~cur.cfg.decrementEnable;
			countUp    = ~cur.cfg.decrementEnable | strobeLevel[i];
			tick       = cur.ctrl.runControl & (cur.ctrl.counterSelect
				? countFall[i] : clockTick(cur.cfg.clockSelect));
			wrap       = 1'b0;
			extSet     = 1'b0;
			hwCount    = cur.count;
			hwReload   = cur.reloadCapture;
			cfgMask    = (i == `UDRCT_INST_TOGGLE_N) ? `UDRCT_CFG_MASK_NOTOG : `UDRCT_CFG_MASK;

			if (cur.ctrl.captureReloadSelect)
			begin
				if (tick)
				begin
					hwCount = countUp ? cur.count + `UDRCT_COUNT_ONE
						: cur.count - `UDRCT_COUNT_ONE;
					wrap    = countUp ? (cur.count == `UDRCT_COUNT_MAX)
						: (cur.count == `UDRCT_COUNT_ZERO);
				end
				if (strobeEdge)
				begin
					hwReload = cur.count;
					extSet   = 1'b1;
				end
			end
			else
			begin
				if (tick)
				begin
					if (countUp && cur.count == `UDRCT_COUNT_MAX)
					begin
						hwCount = cur.reloadCapture;
						wrap    = 1'b1;
					end
					else if (!countUp && cur.count == cur.reloadCapture)
					begin
						hwCount = `UDRCT_COUNT_MAX;
						wrap    = 1'b1;
					end
					else
					begin
						hwCount = countUp ? cur.count + `UDRCT_COUNT_ONE
							: cur.count - `UDRCT_COUNT_ONE;
					end
				end
				// Strobe reload outranks a step in the same cycle
				if (strobeEdge)
				begin
					hwCount = cur.reloadCapture;
					extSet  = 1'b1;
				end
			end

			next_state[i] = cur;
			next_state[i].count = hwCount;
			next_state[i].reloadCapture = hwReload;
			if (hit && accessOff == `UDRCT_OFF_CONTROL)
				next_state[i].ctrl = udrct_ctrl_type'(avsWriteData[7:0] & `UDRCT_CTRL_MASK);
			if (hit && accessOff == `UDRCT_OFF_CONFIG)
				next_state[i].cfg = udrct_cfg_type'(avsWriteData[7:0] & cfgMask);
			// Software byte write beats the hardware step on that byte only
			if (hit && accessOff == `UDRCT_OFF_COUNT_LO)
				next_state[i].count[7:0] = avsWriteData[7:0];
			if (hit && accessOff == `UDRCT_OFF_COUNT_HI)
				next_state[i].count[15:8] = avsWriteData[7:0];
			if (hit && accessOff == `UDRCT_OFF_RC_LO)
				next_state[i].reloadCapture[7:0] = avsWriteData[7:0];
			if (hit && accessOff == `UDRCT_OFF_RC_HI)
				next_state[i].reloadCapture[15:8] = avsWriteData[7:0];

			// Hardware set wins over a clearing write
			if (wrap)
				next_state[i].ctrl.wrapFlag = 1'b1;
			if (extSet)
				next_state[i].ctrl.externalFlag = 1'b1;
			else if (wrap && !cur.ctrl.captureReloadSelect)
				next_state[i].ctrl.externalFlag = ~next_state[i].ctrl.externalFlag;
			if (wrap && cur.cfg.toggleOutputEnable && i != `UDRCT_INST_TOGGLE_N)
				next_state[i].cfg.toggleState = ~next_state[i].cfg.toggleState;

			next_wrapEvent[i] = wrap;
			// Toggle pins come straight from the state flops
			toggleOut[i]       = cur.cfg.toggleState;
			toggleOutEnable[i] = cur.cfg.toggleOutputEnable;
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			for (int i = 0; i < `UDRCT_INSTANCES; i++)
				state[i] <= '0;
			wrapEvent <= '0;
			adcStart  <= '0;
		end
		else
		begin
			for (int i = 0; i < `UDRCT_INSTANCES; i++)
				state[i] <= next_state[i];
			wrapEvent <= next_wrapEvent;
			adcStart  <= next_wrapEvent[`UDRCT_ADC_TRIGGERS-1:0];
		end
	end

endmodule

// File: test/udrct_timer_sva.sv
/*
 Checker of the timer's bus handshake, event and toggle ports.
 Assumes it is bound to udrct_timer and sees only its ports.
*/
`timescale 1ns/10ps
`include "udrct_params.svh"

module udrct_timer_sva
	import udrct_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avsAddress,
	input  wire logic        avsRead,
	input  wire logic        avsWrite,
	input  wire logic [31:0] avsReadData,
	input  wire logic        avsWaitRequest,
	input  wire logic [2:0]  toggleOut,
	input  wire logic [2:0]  toggleOutEnable,
	input  wire logic [2:0]  wrapEvent,
	input  wire logic [1:0]  adcStart
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	logic busReq;
	logic ackRead;
	assign busReq  = avsRead | avsWrite;
	assign ackRead = avsRead & !avsWaitRequest;

	chk_adc_follows_wrap: assert property (adcStart == wrapEvent[1:0])
		else $error("adc start differs from wrap event");
	chk_middle_no_toggle: assert property (toggleOut[1] == 1'b0 && toggleOutEnable[1] == 1'b0)
		else $error("middle instance drives a toggle output");
	chk_one_wait_cycle: assert property (busReq && avsWaitRequest |=> !avsWaitRequest ##1 avsWaitRequest)
		else $error("request not answered after exactly one wait cycle");
	chk_idle_no_ack: assert property (!busReq |=> avsWaitRequest)
		else $error("acknowledge without a request");
	chk_upper_data_zero: assert property (!avsWaitRequest |-> avsReadData[31:8] == 24'h000000)
		else $error("read data above the byte not zero");
	chk_unmapped_zero: assert property (ackRead && avsAddress[7] |-> avsReadData == 32'h00000000)
		else $error("unmapped address read not zero");
	chk_middle_cfg_bits: assert property (ackRead && avsAddress == {1'b0, 2'h1, `UDRCT_OFF_CONFIG}
		|-> avsReadData[7:5] == 3'h0 && avsReadData[2:1] == 2'h0)
		else $error("middle config reads toggle or reserved bits");
	chk_toggle_on_wrap: assert property (toggleOut[0] != $past(toggleOut[0])
		&& !$past(avsWrite && !avsWaitRequest) |-> wrapEvent[0])
		else $error("toggle output moved without a wrap");
endmodule

bind udrct_timer udrct_timer_sva chk (.sys_clk, .rst_n, .avsAddress, .avsRead, .avsWrite,
	.avsReadData, .avsWaitRequest, .toggleOut, .toggleOutEnable, .wrapEvent, .adcStart);

// File: test/udrct_pin_model.sv
/*
 Model of the external pins: count pins, strobe pins and oscillator.
 Assumes the bench calls its tasks right after a rising sys_clk edge.
*/
`timescale 1ns/10ps

module udrct_pin_model
(
	input  wire logic sys_clk,
	output logic      sharedCountPin,
	output logic      sharedStrobePin,
	output logic      ownCountPin,
	output logic      ownStrobePin,
	output logic      oscillatorClock
);
	// Count and strobe pins idle high, so only the tasks make their falling edges
	initial
	begin
		sharedCountPin = 1'b1;
		sharedStrobePin = 1'b1;
		ownCountPin = 1'b1;
		ownStrobePin = 1'b1;
		oscillatorClock = 1'b0;
	end

	// Free running, well below half the system clock
	always #20 oscillatorClock = ~oscillatorClock;

	// Each level held past the three sampling flops
	task countPulse(input logic own);
		if (own) ownCountPin <= 1'b0; else sharedCountPin <= 1'b0;
		repeat (5) @(posedge sys_clk);
		if (own) ownCountPin <= 1'b1; else sharedCountPin <= 1'b1;
		repeat (5) @(posedge sys_clk);
	endtask

	task setStrobe(input logic own, input logic level);
		if (own) ownStrobePin <= level; else sharedStrobePin <= level;
		repeat (6) @(posedge sys_clk);
	endtask
endmodule

// File: test/test_udrct_timer.sv
/*
 Self-checking bench of the timer: register bus, reload, capture,
 direction and clock sources.
 Assumes the pin model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
`include "udrct_params.svh"

module test_udrct_timer;
	import udrct_pkg::*;
	localparam logic [4:0] CTL = `UDRCT_OFF_CONTROL;
	localparam logic [4:0] CFG = `UDRCT_OFF_CONFIG;
	localparam logic [4:0] CLO = `UDRCT_OFF_COUNT_LO;
	localparam logic [4:0] CHI = `UDRCT_OFF_COUNT_HI;
	localparam logic [4:0] RLO = `UDRCT_OFF_RC_LO;
	localparam logic [4:0] RHI = `UDRCT_OFF_RC_HI;
	logic        sys_clk = 1'b0;
	logic        rst_n;
	logic [7:0]  avsAddress;
	logic        avsRead;
	logic        avsWrite;
	logic [31:0] avsWriteData;
	logic [3:0]  avsByteEnable;
	logic [31:0] avsReadData;
	logic        avsWaitRequest;
	logic        sharedCountPin, sharedStrobePin, ownCountPin, ownStrobePin, oscillatorClock;
	logic [2:0]  toggleOut, toggleOutEnable, wrapEvent;
	logic [1:0]  adcStart;
	logic [7:0]  expQ[$], maskQ[$], e, m, v;
	logic [15:0] cnt;
	int          badCount, comparisons, w, seed;
	int          wrapCount[3];
	int          divs[4] = '{12, 1, 80, 2};

	always #2 sys_clk = ~sys_clk;

	udrct_timer dut (.sys_clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
		.avsByteEnable, .avsReadData, .avsWaitRequest, .sharedCountPin, .sharedStrobePin,
		.ownCountPin, .ownStrobePin, .oscillatorClock, .toggleOut, .toggleOutEnable,
		.wrapEvent, .adcStart);
	udrct_pin_model pins (.sys_clk, .sharedCountPin, .sharedStrobePin, .ownCountPin,
		.ownStrobePin, .oscillatorClock);

	////////////////////////////////////////////////////////////////
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			badCount++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	function logic [7:0] ad(input int i, input logic [4:0] o);
		return {1'b0, i[1:0], o};
	endfunction

	// Request held until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= {24'h000000, d};
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avsWaitRequest !== 1'b0 && n < 20);
		if (n >= 20) check("waitrequest", 16'h0001, 16'h0000);
		r = avsReadData[7:0];
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge sys_clk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k, output logic [7:0] r);
		expQ.push_back(x);
		maskQ.push_back(k);
		bus(1'b0, a, 8'h00, r);
	endtask

	task endTest(input string name);
		$display("test %s done", name);
	endtask

	// Read monitor takes the oldest note and counts wrap events
	always @(posedge sys_clk)
	begin
		for (int i = 0; i < 3; i++) wrapCount[i] += (wrapEvent[i] === 1'b1);
		if (avsRead === 1'b1 && avsWaitRequest === 1'b0 && expQ.size() > 0)
		begin
			e = expQ.pop_front();
			m = maskQ.pop_front();
			if (m != 8'h00) check("read data", {8'h00, avsReadData[7:0] & m}, {8'h00, e & m});
		end
	end

	initial
	begin
		repeat (30000) @(posedge sys_clk);
		check("watchdog", 16'h0001, 16'h0000);
		tally_and_finish;
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		{avsAddress, avsRead, avsWrite, avsWriteData, rst_n} = '0;
		avsByteEnable = 4'h1;
		seed = $urandom(9);
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 3; i++)
			for (int o = 0; o < 6; o++) rd(ad(i, 5'(o * 4)), 8'h00, 8'hff, v);
		rd(8'h80, 8'h00, 8'hff, v);
		wr(ad(1, CFG), 8'hff);
		rd(ad(1, CFG), 8'h19, 8'hff, v);
		wr(ad(0, CFG), 8'hff);
		rd(ad(0, CFG), 8'h1f, 8'hff, v);
		check("toggle forced", {15'h0, toggleOut[0]}, 16'h0001);
		avsByteEnable <= 4'h0;
		wr(ad(0, CLO), 8'h55);
		avsByteEnable <= 4'h1;
		rd(ad(0, CLO), 8'h00, 8'hff, v);
		endTest("registers");
		wr(ad(0, RLO), 8'hfd);
		wr(ad(0, RHI), 8'hff);
		wr(ad(0, CLO), 8'hfd);
		wr(ad(0, CHI), 8'hff);
		wr(ad(0, CFG), 8'h02);
		check("toggle cleared", {15'h0, toggleOut[0]}, 16'h0000);
		wr(ad(0, CTL), 8'h06);
		w = wrapCount[0];
		repeat (3) pins.countPulse(1'b0);
		check("reload wraps", 16'(wrapCount[0] - w), 16'h0001);
		check("toggle", {15'h0, toggleOut[0]}, 16'h0001);
		check("toggle enable", {15'h0, toggleOutEnable[0]}, 16'h0001);
		rd(ad(0, CTL), 8'hc6, 8'hff, v);
		rd(ad(0, CLO), 8'hfd, 8'hff, v);
		rd(ad(0, CTL), 8'hc6, 8'hff, v);
		endTest("reload up");
		wr(ad(0, CTL), 8'h0e);
		wr(ad(0, CFG), 8'h01);
		wr(ad(0, CLO), 8'hfe);
		pins.setStrobe(1'b0, 1'b0);
		rd(ad(0, CTL), 8'h0e, 8'hff, v);
		rd(ad(0, CLO), 8'hfe, 8'hff, v);
		w = wrapCount[0];
		repeat (2) pins.countPulse(1'b0);
		rd(ad(0, CLO), 8'hff, 8'hff, v);
		rd(ad(0, CHI), 8'hff, 8'hff, v);
		check("underflow wraps", 16'(wrapCount[0] - w), 16'h0001);
		rd(ad(0, CTL), 8'hce, 8'hff, v);
		pins.setStrobe(1'b0, 1'b1);
		wr(ad(0, CFG), 8'h00);
		wr(ad(0, CTL), 8'h08);
		wr(ad(0, CLO), 8'h12);
		pins.setStrobe(1'b0, 1'b0);
		pins.setStrobe(1'b0, 1'b1);
		rd(ad(0, CLO), 8'hfd, 8'hff, v);
		rd(ad(0, CTL), 8'h48, 8'hff, v);
		wr(ad(0, CTL), 8'h00);
		endTest("reload down");
		cnt = 16'($urandom);
		wr(ad(2, CLO), cnt[7:0]);
		wr(ad(2, CHI), cnt[15:8]);
		wr(ad(2, CTL), 8'h0f);
		repeat (2) pins.countPulse(1'b1);
		cnt = cnt + 16'h0002;
		pins.setStrobe(1'b1, 1'b0);
		pins.setStrobe(1'b1, 1'b1);
		rd(ad(2, RLO), cnt[7:0], 8'hff, v);
		rd(ad(2, RHI), cnt[15:8], 8'hff, v);
		rd(ad(2, CTL), 8'h4f, 8'h7f, v);
		wr(ad(2, CTL), 8'h07);
		wr(ad(2, CLO), 8'h00);
		pins.setStrobe(1'b1, 1'b0);
		pins.setStrobe(1'b1, 1'b1);
		rd(ad(2, RLO), cnt[7:0], 8'hff, v);
		rd(ad(2, CTL), 8'h07, 8'h7f, v);
		endTest("capture");
		wr(ad(1, CLO), 8'hff);
		wr(ad(1, CHI), 8'hff);
		wr(ad(1, CTL), 8'h07);
		w = wrapCount[1];
		pins.countPulse(1'b0);
		rd(ad(1, CTL), 8'h87, 8'hff, v);
		rd(ad(1, CLO), 8'h00, 8'hff, v);
		wr(ad(1, CTL), 8'h0f);
		wr(ad(1, CFG), 8'h01);
		pins.setStrobe(1'b0, 1'b0);
		pins.countPulse(1'b0);
		rd(ad(1, CTL), 8'h8f, 8'hff, v);
		rd(ad(1, CHI), 8'hff, 8'hff, v);
		check("capture wraps", 16'(wrapCount[1] - w), 16'h0002);
		pins.setStrobe(1'b0, 1'b1);
		endTest("capture wrap");
		// Run window is 96 waits plus the start write's closing edge and the two stop request edges
		for (int s = 0; s < 4; s++)
		begin
			wr(ad(2, CTL), 8'h00);
			wr(ad(2, CLO), 8'h00);
			wr(ad(2, CFG), {3'h0, 2'(s), 3'h2});
			wr(ad(2, CTL), 8'h04);
			repeat (96) @(posedge sys_clk);
			wr(ad(2, CTL), 8'h00);
			rd(ad(2, CLO), 8'h00, 8'h00, v);
			w = int'(v) - 99 / divs[s];
			check("clock steps", 16'(!$isunknown(v) && w >= -2 && w <= 2), 16'h0001);
			check("third toggle enable", {15'h0, toggleOutEnable[2]}, 16'h0001);
		end
		endTest("clock select");
		tally_and_finish;
	end
endmodule
